// ==== design/timer_pkg.sv ====
// Shared constants and types for the timer/counter with shared prescaler
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] COUNT_ADDR = 5'h01;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [5:0] CFG_RESET = 6'h3f;
  localparam logic [7:0] SCALER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int INSTR_CLOCKS = 4;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLOCKS = 4'(INHIBIT_INSTR * INSTR_CLOCKS);
  localparam logic [3:0] INHIBIT_NONE = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Internal phases, Gray coded along Q1..Q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } phase_t;

  // Configuration register, bit 5 down to bit 0
  typedef struct packed {
    logic count_source_sel;
    logic count_edge_sel;
    logic scaler_assign;
    logic [2:0] scaler_ratio;
  } timer_cfg_t;

  // One instruction's access to the block
  typedef struct packed {
    logic file_wr;
    logic [4:0] file_addr;
    logic [7:0] wdata;
    logic cfg_wr;
    logic watchdog_clear_instr;
  } cpu_req_t;

endpackage

// ==== design/shared_prescaler.sv ====
// Eight-bit prescaler shared between the timer and the watchdog
`timescale 1ns/1ps
`default_nettype none

module shared_prescaler
  import timer_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [2:0] ratio_i,
  input wire logic to_watchdog_i,
  output logic div_level_o,
  output logic wdt_tick_o
);

  // ----------------------------------------------------------------
  // Count state, never visible outside the module
  // ----------------------------------------------------------------
  logic [7:0] count_q;
  logic [7:0] count_d;

  // Low-bit mask for a ratio, all ones below the selected bit
  function automatic logic [7:0] low_mask(input logic [2:0] ratio);
    low_mask = 8'((9'h001 << ratio) - 9'h001);
  endfunction

  // Next count: clear wins over a tick
  always_comb begin
    count_d = count_q;
    if (clear_i) begin
      count_d = SCALER_RESET;
    end else if (tick_i) begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= SCALER_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bit n is a symmetric square wave at input over 2^(n+1)
  assign div_level_o = count_q[ratio_i];
  // Watchdog gets one pulse per 2^n ticks while it owns the scaler
  assign wdt_tick_o = to_watchdog_i && tick_i &&
                      ((count_q & low_mask(ratio_i)) == low_mask(ratio_i));

endmodule

`default_nettype wire

// ==== design/timer_counter.sv ====
// Eight-bit timer/counter with shared prescaler, instruction-side access
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Source bit clear: count each instruction cycle
// - Count write blocks increments two cycles after
// - Source bit set: count external pin edges
// - Edge bit clear rising, set falling
// - Assign bit picks counter or watchdog scaler
// - Counter scaler ratios 1:2 through 1:256
// - Scaler count has no read/write path
// - Scaler output sampled in phases Q2, Q4
// - Increment lags edge by synchroniser delay
// - Count write clears scaler when counter-owned
// - Watchdog clear clears scaler when watchdog-owned
// - Any reset zeroes the scaler
// - Count register at 01h, read/write, kept
module timer_counter
  import timer_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic device_reset_i,
  input wire cpu_req_t cpu_req_i,
  input wire logic ext_count_input_i,
  input wire logic watchdog_osc_tick_i,
  output logic [1:0] phase_o,
  output logic [7:0] timer_count_o,
  output logic watchdog_tick_o
);

  // ----------------------------------------------------------------
  // Internal phase generator
  // ----------------------------------------------------------------
  phase_t phase_q;
  phase_t phase_d;

  // Q1 -> Q2 -> Q3 -> Q4, one instruction per lap
  always_comb begin
    phase_d = phase_q;
    if (device_reset_i) begin
      phase_d = PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1: phase_d = PH_Q2;
        PH_Q2: phase_d = PH_Q3;
        PH_Q3: phase_d = PH_Q4;
        default: phase_d = PH_Q1;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;

  // ----------------------------------------------------------------
  // Configuration register, write only
  // ----------------------------------------------------------------
  timer_cfg_t cfg_q;
  timer_cfg_t cfg_d;

  // Device resets bring it back to all ones as well
  always_comb begin
    cfg_d = cfg_q;
    if (device_reset_i) begin
      cfg_d = timer_cfg_t'(CFG_RESET);
    end else if (cpu_req_i.cfg_wr) begin
      cfg_d = timer_cfg_t'(cpu_req_i.wdata[5:0]);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= timer_cfg_t'(CFG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic wdo_meta_q;
  logic wdo_sync_q;
  logic wdo_prev_q;
  logic ext_level;
  logic ext_edge;
  logic wdo_edge;

  // Two flops before any logic looks at the pin
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b1; // No edge until the level has been low once
      wdo_meta_q <= 1'b0;
      wdo_sync_q <= 1'b0;
      wdo_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_count_input_i;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_level;
      wdo_meta_q <= watchdog_osc_tick_i;
      wdo_sync_q <= wdo_meta_q;
      wdo_prev_q <= wdo_sync_q;
    end
  end

  // Inverting the pin makes a falling edge look like a rising one
  assign ext_level = ext_sync_q ^ cfg_q.count_edge_sel;
  assign ext_edge = ext_level && !ext_prev_q;
  assign wdo_edge = wdo_sync_q && !wdo_prev_q;

  // ----------------------------------------------------------------
  // Prescaler routing
  // ----------------------------------------------------------------
  logic count_wr;
  logic instr_tick;
  logic scaler_tick;
  logic scaler_clear;
  logic div_level;

  assign count_wr = cpu_req_i.file_wr && (cpu_req_i.file_addr == COUNT_ADDR);
  assign instr_tick = (phase_q == PH_Q4);

  // Scaler sees whichever source its owner uses
  always_comb begin
    if (cfg_q.scaler_assign) begin
      scaler_tick = wdo_edge;
    end else if (cfg_q.count_source_sel) begin
      scaler_tick = ext_edge;
    end else begin
      scaler_tick = instr_tick;
    end
  end

  // Clearing depends on the current owner
  assign scaler_clear = device_reset_i ||
                        (count_wr && !cfg_q.scaler_assign) ||
                        (cpu_req_i.watchdog_clear_instr && cfg_q.scaler_assign);

  // Count value stays inside the submodule; no path reaches it
  shared_prescaler u_scaler (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tick_i(scaler_tick),
    .clear_i(scaler_clear),
    .ratio_i(cfg_q.scaler_ratio),
    .to_watchdog_i(cfg_q.scaler_assign),
    .div_level_o(div_level),
    .wdt_tick_o(watchdog_tick_o)
  );

  // ----------------------------------------------------------------
  // Q2/Q4 sampler of the counter's input level
  // ----------------------------------------------------------------
  logic sample_q;
  logic sample_d;
  logic sample_point;
  logic input_level;
  logic sampled_rise;

  assign sample_point = (phase_q == PH_Q2) || (phase_q == PH_Q4);
  // Without the scaler the synchronised, edge-adjusted pin level is the scaler output
  assign input_level = cfg_q.scaler_assign ? ext_level : div_level;

  always_comb begin
    sample_d = sample_q;
    if (device_reset_i) begin
      sample_d = 1'b1; // Level must be seen low before a rise counts
    end else if (sample_point) begin
      sample_d = input_level;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_q <= 1'b1; // Idle pin after reset must not look like an edge
    end else begin
      sample_q <= sample_d;
    end
  end

  // Only a low-to-high step between two samples counts
  assign sampled_rise = sample_point && input_level && !sample_q;

  // ----------------------------------------------------------------
  // Increment selection and post-write inhibit
  // ----------------------------------------------------------------
  logic [3:0] inhibit_q;
  logic [3:0] inhibit_d;
  logic increment;

  // Direct instruction count needs no sampling; all else is sampled
  always_comb begin
    if (!cfg_q.count_source_sel && cfg_q.scaler_assign) begin
      increment = instr_tick;
    end else begin
      increment = sampled_rise;
    end
  end

  // Software can pre-adjust the written value to cover the lost counts
  always_comb begin
    inhibit_d = inhibit_q;
    if (device_reset_i) begin
      inhibit_d = INHIBIT_NONE;
    end else if (count_wr) begin
      inhibit_d = INHIBIT_CLOCKS;
    end else if (inhibit_q != INHIBIT_NONE) begin
      inhibit_d = inhibit_q - 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      inhibit_q <= INHIBIT_NONE;
    end else begin
      inhibit_q <= inhibit_d;
    end
  end

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  logic [7:0] count_q;
  logic [7:0] count_d;

  // A write beats a same-cycle increment; device resets leave it alone
  always_comb begin
    count_d = count_q;
    if (count_wr) begin
      count_d = cpu_req_i.wdata;
    end else if (increment && (inhibit_q == INHIBIT_NONE)) begin
      count_d = count_q + 8'h01;
    end
  end

  // Power-on value is arbitrary in the part; zero keeps simulation clean
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign timer_count_o = count_q;

endmodule

`default_nettype wire

// ==== tb/timer_counter_props.sv ====
// Port assertions for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer_counter_props
  import timer_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic device_reset_i,
  input wire cpu_req_t cpu_req_i,
  input wire logic [1:0] phase_o,
  input wire logic [7:0] timer_count_o,
  input wire logic watchdog_tick_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------------------------------
  // Config shadow and clocks since the last count write
  // ----------------------------------------------------------------
  timer_cfg_t cfg_q, cfg_d;
  logic [3:0] age_q, age_d;
  logic wr, run, idle;
  logic [1:0] ph_nx;
  assign wr = cpu_req_i.file_wr && cpu_req_i.file_addr == COUNT_ADDR;
  assign ph_nx = {phase_o[0], ~phase_o[1]};
  assign idle = age_q == 4'h0 || age_q > 4'h8;
  // Internal count, no scaler, nothing pending that could move the count
  assign run = !cfg_q.count_source_sel && cfg_q.scaler_assign && !cpu_req_i.cfg_wr && !wr &&
               !device_reset_i;
  // Age saturates so the inhibit window is never seen twice
  always_comb begin
    cfg_d = cpu_req_i.cfg_wr ? timer_cfg_t'(cpu_req_i.wdata[5:0]) : cfg_q;
    age_d = (age_q == 4'h0 || age_q == 4'hf) ? age_q : age_q + 4'h1;
    if (wr)
      age_d = 4'h1;
    if (device_reset_i) begin
      cfg_d = CFG_RESET;
      age_d = 4'h0;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= CFG_RESET;
      age_q <= 4'h0;
    end else begin
      cfg_q <= cfg_d;
      age_q <= age_d;
    end
  end
  a_count_load: assert property (wr |=> timer_count_o == $past(cpu_req_i.wdata))
    else $error("count write not loaded");
  a_write_inhibit: assert property (age_q inside {[1:8]} && !wr |=> $stable(timer_count_o))
    else $error("count moved inside inhibit window");
  a_single_step: assert property (!wr |=> timer_count_o - $past(timer_count_o) <= 8'h01)
    else $error("count jumped by more than one");
  a_q4_only: assert property (run && phase_o != PH_Q4 |=> $stable(timer_count_o))
    else $error("internal count moved off Q4");
  a_q4_tick: assert property (run && idle && phase_o == PH_Q4
    |=> timer_count_o == $past(timer_count_o) + 8'h01)
    else $error("internal count missed Q4");
  a_phase_ring: assert property (!device_reset_i |=> phase_o == $past(ph_nx))
    else $error("phase order broken");
  a_phase_restart: assert property (device_reset_i |=> phase_o == PH_Q1)
    else $error("phase not Q1 after device reset");
  a_reset_keeps: assert property (device_reset_i && !wr |=> $stable(timer_count_o))
    else $error("device reset changed count");
  a_wdt_owner: assert property (watchdog_tick_o |-> cfg_q.scaler_assign)
    else $error("watchdog tick while scaler on counter");
  c_write: cover property (wr);
  c_wdt: cover property (watchdog_tick_o);
  c_ext: cover property (cfg_q.count_source_sel && $changed(timer_count_o));
endmodule
`default_nettype wire

// ==== tb/ext_count_source.sv ====
// Far-side model of the external count source
`timescale 1ns/1ps
`default_nettype none
module ext_count_source (
  input wire logic clock_i,
  output logic pin_o
);
  // Idles high so the falling-edge reset mode sees no edge
  initial pin_o = 1'b1;
  // Never holds a level under two clocks, the pin's legal minimum
  task automatic drive(input logic v, input int hold);
    pin_o <= v;
    repeat (hold < 2 ? 2 : hold) @(posedge clock_i);
  endtask
  // One whole pulse; a larger half period gives a slow source
  task automatic pulse(input int half);
    drive(1'b1, half);
    drive(1'b0, half);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_timer_counter.sv ====
// Self-checking testbench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter;
  import timer_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic device_reset_i = 1'b0;
  cpu_req_t cpu_req_i = '0;
  logic watchdog_osc_tick_i = 1'b0;
  wire logic ext_count_input_i;
  logic [1:0] phase_o;
  logic [7:0] timer_count_o;
  logic watchdog_tick_o;
  int n_fail = 0;
  int total_checks = 0;
  int ticks = 0;
  logic [8:0] exp_q[$];
  logic [7:0] base;
  event chk_ev;
  // ----------------------------------------------------------------
  // Clock, design and far-side source
  // ----------------------------------------------------------------
  always #2.5 clock_i = ~clock_i;
  timer_counter u_timer_counter (.clock_i(clock_i), .resetn_i(resetn_i),
    .device_reset_i(device_reset_i), .cpu_req_i(cpu_req_i),
    .ext_count_input_i(ext_count_input_i), .watchdog_osc_tick_i(watchdog_osc_tick_i),
    .phase_o(phase_o), .timer_count_o(timer_count_o), .watchdog_tick_o(watchdog_tick_o));
  ext_count_source u_ext_count_source (.clock_i(clock_i), .pin_o(ext_count_input_i));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One strobe, held across exactly one sampling edge
  task automatic req(input cpu_req_t r);
    @(posedge clock_i);
    cpu_req_i <= r;
    @(posedge clock_i);
    cpu_req_i <= '0;
  endtask
  task automatic wr_count(input logic [4:0] a, input logic [7:0] d);
    req('{1'b1, a, d, 1'b0, 1'b0});
  endtask
  task automatic wr_cfg(input logic [5:0] c);
    req('{1'b0, 5'h00, {2'b00, c}, 1'b1, 1'b0});
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      watchdog_osc_tick_i <= 1'b1;
      cyc(4);
      watchdog_osc_tick_i <= 1'b0;
      cyc(4);
    end
  endtask
  // Bit 8 of a note picks the tick total instead of the count
  task automatic note(input logic k, input logic [7:0] v);
    exp_q.push_back({k, v});
    #1;
    -> chk_ev;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge clock_i) if (watchdog_tick_o === 1'b1) ticks <= ticks + 1;
  always @(chk_ev) begin
    cmp8(exp_q[0][8] ? 8'(ticks) : timer_count_o, exp_q[0][7:0]);
    void'(exp_q.pop_front());
  end
  // Hang guard, well beyond the few thousand cycles the run needs
  initial begin
    cyc(20000);
    n_fail++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(45409));
    cyc(10);
    resetn_i <= 1'b1;
    cyc(2);
    note(1'b0, COUNT_RESET);
    // Internal source, no scaler: write blocks counting, then one per instruction
    wr_cfg(6'h08);
    base = 8'($urandom);
    wr_count(COUNT_ADDR, base);
    cyc(8);
    note(1'b0, base);
    cyc(4);
    note(1'b0, base + 8'h01);
    cyc(40);
    note(1'b0, base + 8'h0b);
    // External pin, rising then falling; an unmapped write is ignored
    for (int e = 0; e < 2; e++) begin
      u_ext_count_source.drive(1'b0, 4);
      wr_cfg({1'b1, e[0], 4'b1111});
      cyc(12);
      base = 8'($urandom);
      wr_count(COUNT_ADDR, base);
      wr_count(5'h02, ~base);
      cyc(10);
      u_ext_count_source.drive(1'b1, 10);
      note(1'b0, base + 8'(1 - e));
      u_ext_count_source.drive(1'b0, 10);
      note(1'b0, base + 8'h01);
      repeat (4) u_ext_count_source.pulse(2);
      cyc(8);
      note(1'b0, base + 8'h05);
    end
    // Scaler on counter: stale scaler state must be wiped by the count write
    for (int n = 0; n < 8; n++) begin
      wr_cfg({3'b100, 3'(n)});
      repeat (1 << n) u_ext_count_source.pulse(2);
      base = 8'($urandom);
      wr_count(COUNT_ADDR, base);
      cyc(10);
      repeat (3 << n) u_ext_count_source.pulse(2);
      cyc(8);
      note(1'b0, base + 8'h02);
    end
    // Scaler on watchdog, ratio 2, in the safe order, then handed back to the counter
    req('{1'b0, 5'h00, 8'h00, 1'b0, 1'b1});
    wr_count(COUNT_ADDR, 8'h00);
    wr_cfg(6'h0a);
    osc(16);
    note(1'b1, 8'h04);
    // Stale low bits would give a tick within three edges unless the clear wipes them
    osc(2);
    req('{1'b0, 5'h00, 8'h00, 1'b0, 1'b1});
    osc(3);
    note(1'b1, 8'h04);
    req('{1'b0, 5'h00, 8'h00, 1'b0, 1'b1});
    wr_cfg(6'h02);
    osc(16);
    note(1'b1, 8'h04);
    // Device reset keeps the count and restores the configuration
    u_ext_count_source.drive(1'b1, 4);
    base = 8'($urandom);
    wr_count(COUNT_ADDR, base);
    cyc(10);
    device_reset_i <= 1'b1;
    cyc(1);
    device_reset_i <= 1'b0;
    cyc(10);
    note(1'b0, base);
    u_ext_count_source.drive(1'b0, 10);
    note(1'b0, base + 8'h01);
    cyc(2);
    final_report();
  end
endmodule
bind timer_counter timer_counter_props u_timer_counter_props (.clock_i(clock_i),
  .resetn_i(resetn_i), .device_reset_i(device_reset_i), .cpu_req_i(cpu_req_i),
  .phase_o(phase_o), .timer_count_o(timer_count_o), .watchdog_tick_o(watchdog_tick_o));
`default_nettype wire
